// ==== rtl/ursf_pkg.sv ====
package ursf_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [3:0] STATUS_OFF  = 4'h0;
	localparam logic [3:0] DATA_OFF    = 4'h4;
	localparam logic [3:0] EVENT_OFF   = 4'h8;
	localparam logic [3:0] MASK_OFF    = 4'hc;
	// ==========================================
	// Status field positions
	localparam int IDLE_BIT  = 4;
	localparam int HEAD_PARITY_ERROR_FLAG_BIT  = 3;
	localparam int HEAD_FRAMING_ERROR_FLAG_BIT  = 2;
	localparam int OVR_BIT   = 1;
	localparam int AVAIL_BIT = 0;
	// ==========================================
	// Event bits
	localparam int EV_CHAR   = 0;
	localparam int EV_OVR    = 1;
	localparam int EV_ERR    = 2;
	localparam int EV_W      = 3;
	// ==========================================
	// Sizes and reset values
	localparam int FIFO_DEPTH = 4;
	localparam int DATA_W     = 9;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Oversampling: ticks of baud enable per bit
	localparam int OVS = 16;
	localparam logic [15:0] DIV_RST = 16'h006b;
endpackage

// ==== rtl/ursf_rx_if.sv ====
`timescale 1ns/1ps
interface ursf_rx_if;
	logic                         charValid;
	logic [ursf_pkg::DATA_W-1:0]  charData;
	logic                         charPerr;
	logic                         charFerr;
	logic                         busy;
	logic                         flush;
	modport rx  (output charValid, charData, charPerr, charFerr, busy, input flush);
	modport top (input charValid, charData, charPerr, charFerr, busy, output flush);
endinterface

// ==== rtl/ursf_rx_shift.sv ====
`timescale 1ns/1ps
// Receive shift register: 8 data bits, optional parity, one stop bit.
module ursf_rx_shift (
	input  wire logic        clk,        // System clock
	input  wire logic        arst_n,     // Async reset, active low
	input  wire logic        ce,         // Clock enable
	input  wire logic        rxSync,     // Synchronised serial line
	input  wire logic [15:0] divisor,    // Clocks per oversample tick minus one
	input  wire logic        parityEn,   // Parity bit present
	input  wire logic        parityOdd,  // Odd parity when set
	ursf_rx_if.rx            rx          // Character out, flush in
);
	typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ursf_state_e;
	ursf_state_e state_r;
	logic [15:0] divCnt_r;
	logic [3:0]  ovs_r;
	logic [2:0]  bitCnt_r;
	logic [7:0]  shift_r;
	logic        parBit_r;
	logic        tick;

	assign tick = (divCnt_r == divisor);
	assign rx.busy = (state_r != ST_IDLE);

	// ==========================================
	// Oversample tick generator
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt_r <= 16'h0000;
		end else if (ce) begin
			divCnt_r <= (tick || state_r == ST_IDLE) ? 16'h0000 : divCnt_r + 16'h0001;
		end
	end

	// ==========================================
	// Bit sequencer; flush returns it to idle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r      <= ST_IDLE;
			ovs_r        <= 4'h0;
			bitCnt_r     <= 3'h0;
			shift_r      <= 8'h00;
			parBit_r     <= 1'b0;
			rx.charValid <= 1'b0;
			rx.charData  <= '0;
			rx.charPerr  <= 1'b0;
			rx.charFerr  <= 1'b0;
		end else if (ce) begin
			rx.charValid <= 1'b0;
			if (rx.flush) begin
				state_r <= ST_IDLE;
				shift_r <= 8'h00;
			end else begin
				case (state_r)
				ST_IDLE: begin
					ovs_r <= 4'h0;
					if (!rxSync) begin
						state_r <= ST_START;
					end
				end
				ST_START: if (tick) begin
					ovs_r <= ovs_r + 4'h1;
					// Mid-bit check rejects glitches
					if (ovs_r == 4'(ursf_pkg::OVS/2 - 1)) begin
						ovs_r   <= 4'h0;
						state_r <= rxSync ? ST_IDLE : ST_DATA;
						bitCnt_r <= 3'h0;
					end
				end
				ST_DATA: if (tick) begin
					ovs_r <= ovs_r + 4'h1;
					if (ovs_r == 4'(ursf_pkg::OVS - 1)) begin
						shift_r  <= {rxSync, shift_r[7:1]};
						bitCnt_r <= bitCnt_r + 3'h1;
						if (bitCnt_r == 3'h7) begin
							state_r <= parityEn ? ST_PAR : ST_STOP;
						end
					end
				end
				ST_PAR: if (tick) begin
					ovs_r <= ovs_r + 4'h1;
					if (ovs_r == 4'(ursf_pkg::OVS - 1)) begin
						parBit_r <= rxSync;
						state_r  <= ST_STOP;
					end
				end
				ST_STOP: if (tick) begin
					ovs_r <= ovs_r + 4'h1;
					if (ovs_r == 4'(ursf_pkg::OVS - 1)) begin
						rx.charValid <= 1'b1;
						rx.charData  <= {parityEn & parBit_r, shift_r};
						rx.charPerr  <= parityEn & ((^shift_r ^ parBit_r) != parityOdd);
						rx.charFerr  <= !rxSync;
						state_r      <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// ==== rtl/ursf_top.sv ====
`timescale 1ns/1ps
module ursf_top #(
	parameter int DEPTH = ursf_pkg::FIFO_DEPTH  // FIFO entries
) (
	input  wire logic        clk,      // 200 MHz system clock
	input  wire logic        arst_n,   // Async reset, active low
	input  wire logic        ce,       // Clock enable, freezes all state
	input  wire logic        rxPin,    // Serial receive line
	input  wire logic [3:0]  awaddr,   // AXI write address
	input  wire logic        awvalid,  // AXI write address valid
	output logic             awready,  // AXI write address ready
	input  wire logic [31:0] wdata,    // AXI write data
	input  wire logic [3:0]  wstrb,    // AXI write strobes
	input  wire logic        wvalid,   // AXI write data valid
	output logic             wready,   // AXI write data ready
	output logic [1:0]       bresp,    // AXI write response
	output logic             bvalid,   // AXI write response valid
	input  wire logic        bready,   // AXI write response ready
	input  wire logic [3:0]  araddr,   // AXI read address
	input  wire logic        arvalid,  // AXI read address valid
	output logic             arready,  // AXI read address ready
	output logic [31:0]      rdata,    // AXI read data
	output logic [1:0]       rresp,    // AXI read response
	output logic             rvalid,   // AXI read valid
	input  wire logic        rready,   // AXI read ready
	output logic             irq       // Level interrupt
);
	localparam int AW = $clog2(DEPTH);
	ursf_rx_if rxIf ();

	logic [1:0]                   rxSync_r;
	logic [ursf_pkg::DATA_W+1:0]  mem_r [DEPTH];
	logic [AW-1:0]                wrPtr_r, rdPtr_r;
	logic [AW:0]                  count_r;
	logic                         ovr_r;
	logic [15:0]                  div_r;
	logic                         parEn_r, parOdd_r;
	logic [ursf_pkg::EV_W-1:0]    event_r, mask_r;
	logic [ursf_pkg::EV_W-1:0]    evSet, evClr;
	logic [3:0]                   awAddr_r;
	logic [31:0]                  wData_r;
	logic [3:0]                   wStrb_r;
	logic                         awHave_r, wHave_r;
	logic [4:0]                   status;
	logic                         doWrite, doRead, push, pop, full, empty, ovrClear, accept;
	logic [ursf_pkg::DATA_W+1:0]  head;

	// ==========================================
	// Line synchroniser
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxSync_r <= 2'b11;
		end else if (ce) begin
			rxSync_r <= {rxSync_r[0], rxPin};
		end
	end

	ursf_rx_shift u_shift (
		.clk       (clk),
		.arst_n    (arst_n),
		.ce        (ce),
		.rxSync    (rxSync_r[1]),
		.divisor   (div_r),
		.parityEn  (parEn_r),
		.parityOdd (parOdd_r),
		.rx        (rxIf.rx)
	);

	// ==========================================
	// Receive FIFO
	assign full   = (count_r == (AW+1)'(DEPTH));
	assign empty  = (count_r == '0);
	assign head   = mem_r[rdPtr_r];
	// Halt while overrun stands so software sees the oldest data intact
	assign accept = rxIf.charValid && !ovr_r;
	assign push   = accept && !full;
	assign pop    = doRead && (araddr == ursf_pkg::DATA_OFF) && !empty;
	assign ovrClear = doWrite && (awAddr_r == ursf_pkg::STATUS_OFF) && wStrb_r[0]
	                  && ovr_r && !wData_r[ursf_pkg::OVR_BIT];
	assign rxIf.flush = ovrClear;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_r[wrPtr_r] <= {rxIf.charPerr, rxIf.charFerr, rxIf.charData};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (ce) begin
			if (ovrClear) begin
				wrPtr_r <= '0;
				rdPtr_r <= '0;
				count_r <= '0;
			end else begin
				// DEPTH-deep queue, pointers wrap at DEPTH
				if (push) wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
				if (pop) rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
				count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
			end
		end
	end

	// ==========================================
	// Overrun flag: only hardware sets it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovr_r <= 1'b0;
		end else if (ce) begin
			if (accept && full) begin
				ovr_r <= 1'b1;
			end else if (ovrClear) begin
				ovr_r <= 1'b0;
			end
		end
	end

	// ==========================================
	// Status word
	always_comb begin
		status = '0;
		status[ursf_pkg::IDLE_BIT]  = !rxIf.busy;
		status[ursf_pkg::HEAD_PARITY_ERROR_FLAG_BIT]  = !empty && head[ursf_pkg::DATA_W+1];
		status[ursf_pkg::HEAD_FRAMING_ERROR_FLAG_BIT]  = !empty && head[ursf_pkg::DATA_W];
		status[ursf_pkg::OVR_BIT]   = ovr_r;
		status[ursf_pkg::AVAIL_BIT] = !empty;
	end

	// ==========================================
	// Events and interrupt; set wins over write-one clear
	always_comb begin
		evSet = '0;
		evClr = '0;
		evSet[ursf_pkg::EV_CHAR] = push;
		evSet[ursf_pkg::EV_OVR]  = accept && full;
		evSet[ursf_pkg::EV_ERR]  = push && (rxIf.charPerr || rxIf.charFerr);
		if (doWrite && awAddr_r == ursf_pkg::EVENT_OFF && wStrb_r[0]) begin
			evClr = wData_r[ursf_pkg::EV_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			event_r <= '0;
		end else if (ce) begin
			event_r <= (event_r & ~evClr) | evSet;
		end
	end
	assign irq = |(event_r & mask_r);

	// ==========================================
	// AXI4-Lite write side
	assign awready = !awHave_r && !bvalid;
	assign wready  = !wHave_r && !bvalid;
	assign doWrite = awHave_r && wHave_r && !bvalid;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awHave_r <= 1'b0;
			wHave_r  <= 1'b0;
			awAddr_r <= '0;
			wData_r  <= '0;
			wStrb_r  <= '0;
			bvalid   <= 1'b0;
			bresp    <= ursf_pkg::RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wHave_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			if (doWrite) begin
				awHave_r <= 1'b0;
				wHave_r  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= (awAddr_r == ursf_pkg::DATA_OFF) ? ursf_pkg::RESP_SLVERR : ursf_pkg::RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Control: mask, divisor and parity in mask reg; data-reg write is refused
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_r   <= ursf_pkg::MASK_RST;
			div_r    <= ursf_pkg::DIV_RST;
			parEn_r  <= 1'b0;
			parOdd_r <= 1'b0;
		end else if (ce && doWrite) begin
			if (awAddr_r == ursf_pkg::MASK_OFF) begin
				if (wStrb_r[0]) mask_r <= wData_r[ursf_pkg::EV_W-1:0];
				if (wStrb_r[1]) parEn_r <= wData_r[8];
				if (wStrb_r[1]) parOdd_r <= wData_r[9];
				if (wStrb_r[2]) div_r[7:0] <= wData_r[23:16];
				if (wStrb_r[3]) div_r[15:8] <= wData_r[31:24];
			end
		end
	end

	// ==========================================
	// AXI4-Lite read side; data read pops the head
	assign arready = !rvalid;
	assign doRead  = arvalid && arready;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= ursf_pkg::RESP_OKAY;
		end else if (ce) begin
			if (doRead) begin
				rvalid <= 1'b1;
				rresp  <= ursf_pkg::RESP_OKAY;
				case (araddr)
				ursf_pkg::STATUS_OFF: rdata <= {27'h0, status};
				ursf_pkg::DATA_OFF:   rdata <= empty ? 32'h0 : {23'h0, head[ursf_pkg::DATA_W-1:0]};
				ursf_pkg::EVENT_OFF:  rdata <= {29'h0, event_r};
				ursf_pkg::MASK_OFF:   rdata <= {div_r, 6'h0, parOdd_r, parEn_r, 5'h0, mask_r};
				default: begin
					rdata <= '0;
					rresp <= ursf_pkg::RESP_SLVERR;
				end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule

// ==== sim/ursf_serial_tx.sv ====
`timescale 1ns/1ps
// Remote transmitter: idle-high line, LSB first, fixed bit time
module ursf_serial_tx #(
	parameter int BIT_CLKS = 16  // Clocks per bit
) (
	input  wire logic        clk,    // Clock
	input  wire logic        go,     // Start a frame
	input  wire logic [10:0] frame,  // Bits, start bit first
	input  wire logic [3:0]  nBits,  // Bits in frame
	output logic             line,   // Serial line
	output logic             busy    // Frame under way
);
	logic [10:0] sh_r;
	int          cnt;
	int          left;
	initial begin
		line = 1'b1;
		busy = 1'b0;
	end
	// ==========
	// Frame shifter
	// Line rests at mark level between frames, as a pulled-up wire would
	always @(posedge clk) begin
		if (!busy && go) begin
			sh_r <= frame >> 1;
			line <= frame[0];
			left <= nBits - 1;
			cnt <= BIT_CLKS - 1;
			busy <= 1'b1;
		end else if (busy && cnt != 0) begin
			cnt <= cnt - 1;
		end else if (busy && left == 0) begin
			busy <= 1'b0;
			line <= 1'b1;
		end else if (busy) begin
			line <= sh_r[0];
			sh_r <= sh_r >> 1;
			left <= left - 1;
			cnt <= BIT_CLKS - 1;
		end
	end
endmodule

// ==== sim/ursf_top_properties.sv ====
`timescale 1ns/1ps
module ursf_top_properties (
	input wire logic        clk,     // Clock
	input wire logic        arst_n,  // Reset
	input wire logic [3:0]  awaddr,  // Write address
	input wire logic        awvalid, // Address valid
	input wire logic [31:0] wdata,   // Write data
	input wire logic [3:0]  wstrb,   // Strobes
	input wire logic        wvalid,  // Data valid
	input wire logic        bvalid,  // Response valid
	input wire logic        bready,  // Response ready
	input wire logic [3:0]  araddr,  // Read address
	input wire logic        arvalid, // Read valid
	input wire logic        arready, // Read ready
	input wire logic [31:0] rdata,   // Read data
	input wire logic        rvalid,  // Data valid
	input wire logic        rready   // Data ready
);
	logic [3:0] rdAddr_r;
	logic       ovrSeen_r;
	logic       clrWr_r;
	wire        stRd = rvalid && rready && rdAddr_r == ursf_pkg::STATUS_OFF;
	wire        dRd = rvalid && rready && rdAddr_r == ursf_pkg::DATA_OFF;
	// ==========
	// Tracking
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdAddr_r <= 4'h0;
		end else if (arvalid && arready) begin
			rdAddr_r <= araddr;
		end
	end
	// Only a clearing write may turn a seen overrun off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovrSeen_r <= 1'b0;
			clrWr_r <= 1'b0;
		end else begin
			if (stRd) begin
				ovrSeen_r <= rdata[1];
				clrWr_r <= 1'b0;
			end
			if (awvalid && wvalid && awaddr == ursf_pkg::STATUS_OFF && wstrb[0] && !wdata[1]) begin
				clrWr_r <= 1'b1;
			end
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_status_rsvd: assert property (stRd |-> rdata[31:5] == 27'h0) else $error("status upper bits set");
	a_head_parity_error_flag_empty: assert property (stRd && !rdata[0] |-> !rdata[3]) else $error("parity flag on empty");
	a_head_framing_error_flag_empty: assert property (stRd && !rdata[0] |-> !rdata[2]) else $error("framing flag on empty");
	a_ovr_sticky: assert property (stRd && ovrSeen_r && !rdata[1] |-> clrWr_r) else $error("overrun lost");
	a_wr_once: assert property (bvalid && bready |=> !bvalid) else $error("write response repeated");
	a_data_width: assert property (dRd |-> rdata[31:9] == 23'h0) else $error("data upper bits set");
	a_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
	a_rd_once: assert property (rvalid && rready |=> !rvalid) else $error("read response repeated");
	c_overrun: cover property (stRd && rdata[1]);
	c_parity: cover property (stRd && rdata[3]);
	c_framing: cover property (stRd && rdata[2]);
endmodule
bind ursf_top ursf_top_properties ursf_top_properties_i (.clk(clk), .arst_n(arst_n), .awaddr(awaddr),
	.awvalid(awvalid), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));

// ==== sim/ursf_top_test.sv ====
`timescale 1ns/1ps
module ursf_top_test;
	logic        clk, arst_n, go, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0]  awaddr, araddr, nb;
	logic [31:0] wdata, rv;
	logic [10:0] frm;
	logic [1:0]  rr, br;
	logic [7:0]  q[6];
	wire logic   rxPin, txBusy, awready, wready, bvalid, arready, rvalid, irq;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          n_mismatch, comparisons, seed, i;
	ursf_top #(.DEPTH(ursf_pkg::FIFO_DEPTH)) ursf_top_i (.clk(clk), .arst_n(arst_n), .ce(1'b1), .rxPin(rxPin),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
	ursf_serial_tx #(.BIT_CLKS(16)) ursf_serial_tx_i (.clk(clk), .go(go), .frame(frm), .nBits(nb),
		.line(rxPin), .busy(txBusy));
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic hang;
		n_mismatch++;
		$display("wrong value wait expected done seen timeout");
		stop_test();
	endtask
	// ==========
	// Bus master, signals move only after an edge
	// Local flags track what is still open; the driven regs only update after the edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw, w, b;
		{aw, w, b} = 3'h7;
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		for (int k = 0; aw || w || b; k++) begin
			if (k == 200) hang();
			@(posedge clk);
			if (aw && awready) begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && wready) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
			if (b && bvalid) begin
				bready <= 1'b0;
				br = bresp;
				b = 1'b0;
			end
		end
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		logic ar, r;
		{ar, r} = 2'h3;
		{araddr, arvalid, rready} <= {a, 2'h3};
		for (int k = 0; ar || r; k++) begin
			if (k == 200) hang();
			@(posedge clk);
			if (ar && arready) begin
				arvalid <= 1'b0;
				ar = 1'b0;
			end
			if (r && rvalid) begin
				rready <= 1'b0;
				d = rdata;
				rr = rresp;
				r = 1'b0;
			end
		end
		@(posedge clk);
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		rd(a, d);
		chk(nm, e, d);
	endtask
	// ==========
	// Partner control
	function automatic logic [14:0] fr(input logic [7:0] b, input logic pe, input logic p, input logic stp);
		fr = pe ? {stp, p, b, 1'b0, 4'hb} : {1'b1, stp, b, 1'b0, 4'ha};
	endfunction
	task automatic tx(input logic [7:0] b, input logic pe, input logic p, input logic stp);
		{frm, nb, go} <= {fr(b, pe, p, stp), 1'b1};
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic txw;
		for (int k = 0; k < 2 || txBusy; k++) begin
			if (k == 400) hang();
			@(posedge clk);
		end
		// A low stop bit looks like a start edge; let the mid-bit recheck drop it
		repeat (8) @(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		seed = 32'h28b5;
		{arst_n, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, go, frm, nb} = '0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rc(ursf_pkg::STATUS_OFF, 32'h10, "status at reset");
		rc(ursf_pkg::MASK_OFF, 32'h006b0000, "control at reset");
		rd(4'h2, rv);
		chk("unmapped response", {30'h0, ursf_pkg::RESP_SLVERR}, {30'h0, rr});
		wr(ursf_pkg::DATA_OFF, 32'h0);
		chk("data write response", {30'h0, ursf_pkg::RESP_SLVERR}, {30'h0, br});
		$display("test reset done");
		wr(ursf_pkg::MASK_OFF, 32'h0);
		for (i = 0; i < 4; i++) begin
			q[i] = 8'($random(seed));
			tx(q[i], 1'b0, 1'b0, 1'b1);
			repeat (8) @(posedge clk);
			rc(ursf_pkg::STATUS_OFF, {31'h0, i != 0}, "status mid frame");
			txw();
		end
		rc(ursf_pkg::STATUS_OFF, 32'h11, "status four held");
		for (i = 0; i < 4; i++) rc(ursf_pkg::DATA_OFF, {24'h0, q[i]}, "fifo order");
		rc(ursf_pkg::STATUS_OFF, 32'h10, "status drained");
		$display("test fifo done");
		wr(ursf_pkg::MASK_OFF, 32'h100);
		for (i = 0; i < 3; i++) begin
			q[i] = 8'($random(seed));
			tx(q[i], 1'b1, (^q[i]) ^ (i == 1), i != 2);
			txw();
		end
		rc(ursf_pkg::STATUS_OFF, 32'h11, "head clean");
		rc(ursf_pkg::DATA_OFF, {23'h0, ^q[0], q[0]}, "data with parity");
		rc(ursf_pkg::STATUS_OFF, 32'h19, "head parity error");
		rc(ursf_pkg::DATA_OFF, {23'h0, ~^q[1], q[1]}, "data bad parity");
		rc(ursf_pkg::STATUS_OFF, 32'h15, "head framing error");
		rc(ursf_pkg::DATA_OFF, {23'h0, ^q[2], q[2]}, "data bad stop");
		rc(ursf_pkg::STATUS_OFF, 32'h10, "errors gone with head");
		$display("test errors done");
		wr(ursf_pkg::MASK_OFF, 32'h2);
		wr(ursf_pkg::EVENT_OFF, 32'h7);
		for (i = 0; i < 6; i++) begin
			q[i] = 8'($random(seed));
			tx(q[i], 1'b0, 1'b0, 1'b1);
			txw();
			if (i == 4) rc(ursf_pkg::DATA_OFF, {24'h0, q[0]}, "oldest kept");
		end
		rc(ursf_pkg::STATUS_OFF, 32'h13, "overrun set");
		rc(ursf_pkg::EVENT_OFF, 32'h3, "events pushed and overrun");
		chk("irq unmasked", 32'h1, {31'h0, irq});
		rc(ursf_pkg::DATA_OFF, {24'h0, q[1]}, "later char dropped");
		wr(ursf_pkg::STATUS_OFF, 32'h0);
		rc(ursf_pkg::STATUS_OFF, 32'h10, "flushed on clear");
		wr(ursf_pkg::EVENT_OFF, 32'h2);
		chk("irq after event clear", 32'h0, {31'h0, irq});
		wr(ursf_pkg::STATUS_OFF, 32'h2);
		rc(ursf_pkg::STATUS_OFF, 32'h10, "software cannot set");
		tx(q[5], 1'b0, 1'b0, 1'b1);
		txw();
		rc(ursf_pkg::DATA_OFF, {24'h0, q[5]}, "reception resumed");
		$display("test overrun done");
		stop_test();
	end
endmodule
